// ---- include/irq_pkg.sv ----
package irq_pkg;

   // bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned NUM_SRC = 15;
   localparam int unsigned NUM_PINS = 32;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_EXT_FLAGS = 10'h091;
   localparam logic [9:0] IDX_BASE_EN = 10'h0a8;
   localparam logic [9:0] IDX_BASE_PRIO = 10'h0b8;
   localparam logic [9:0] IDX_EXT_EN = 10'h0e8;
   localparam logic [9:0] IDX_EXT_PRIO = 10'h0f8;
   localparam logic [9:0] IDX_PIN_GROUP = 10'h100;
   localparam logic [9:0] IDX_PIN_RISE = 10'h101;
   localparam logic [9:0] IDX_PIN_FALL = 10'h102;
   localparam logic [9:0] IDX_PIN_FLAGS = 10'h103;
   localparam logic [9:0] IDX_PIN_WAKE = 10'h104;
   localparam logic [9:0] IDX_CORE_STAT = 10'h105;

   // reset values
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [31:0] RST_REG32 = 32'h0000_0000;

   // field positions
   localparam int unsigned BIT_GLOBAL_EN = 7;
   localparam int unsigned BIT_I2C_FLAG = 0;
   localparam int unsigned BIT_BASE_UNUSED = 7;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // request flags arriving from peripherals, all levels except i2c_master_set
   typedef struct packed {
      logic [3:0] rtc_timer_other;
      logic       rtc_quarter_second_event;
      logic       rtc_alarm_event;
      logic       rtc_second_event;
      logic [2:0] spi_slave_src;
      logic [2:0] pca_src;
      logic [1:0] adc_pwm_src;
      logic [4:0] comparator_can_src;
      logic [1:0] low_voltage_src;
      logic       i2c_master_set;
      logic       watchdog_flag;
      logic       uart2_flag;
      logic       timer2_flag;
      logic       uart0_flag;
      logic       timer1_flag;
      logic       timer0_flag;
   } irq_sources_s;

   // winner handed to the core vectoring logic
   typedef struct packed {
      logic       valid;
      logic       high;
      logic [3:0] index;
   } core_request_s;

endpackage

// ---- rtl/extended_irq_ctrl.sv ----
// Contract
// - extended enable bits seven down to zero
// - low voltage bit2, i2c master bit0; the code places low voltage at bit1
// - priority bit one means high level
// - base priority bits six..zero, bit7 unused
// - extended priority mirrors extended enable layout
// - extended flag layout, bit four reserved
// - writes to peripheral line flags ignored
// - i2c master flag cleared only by software
// - line flags follow sources without storage
// - rtc line flag ORs all its sources
// - set source keeps line asserted after return
// - each pin selects group zero or one
// - per-pin rising, falling or both edges
// - same edge detection produces wake-up
// - high level first, then natural order
// - requests sampled on rising system clock
// - software writes only clear flags
// - global enable gates all peripheral interrupts
module extended_irq_ctrl
   import irq_pkg::*;
#(
   parameter int unsigned N_PINS = irq_pkg::NUM_PINS
) (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic                      ce,
   input  wire logic [irq_pkg::ADDR_W-1:0] awaddr,
   input  wire logic [2:0]                awprot,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [irq_pkg::DATA_W-1:0] wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   input  wire logic [irq_pkg::ADDR_W-1:0] araddr,
   input  wire logic [2:0]                arprot,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [irq_pkg::DATA_W-1:0]     rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   input  wire irq_pkg::irq_sources_s     sources,
   input  wire logic [N_PINS-1:0]         gpio_pins,
   output irq_pkg::core_request_s         core_request,
   output logic [irq_pkg::NUM_SRC-1:0]    line_requests,
   output logic                           pin_irq_group0,
   output logic                           pin_irq_group1,
   output logic                           wake_event
);
   import irq_pkg::*;

   // software-visible state, plus the previous pin levels
   logic [7:0]        base_enable_reg;
   logic [7:0]        base_priority_reg;
   logic [7:0]        extended_enable_reg;
   logic [7:0]        extended_priority_reg;
   logic              i2c_master_line_flag;
   logic [N_PINS-1:0] pin_function_config;
   logic [N_PINS-1:0] pin_rise_en;
   logic [N_PINS-1:0] pin_fall_en;
   logic [N_PINS-1:0] pin_wake_en;
   logic [N_PINS-1:0] pin_flags;
   logic [N_PINS-1:0] pin_prev;

   // bus holding registers
   logic              aw_full;
   logic              w_full;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [DATA_W-1:0] w_data_q;
   logic [3:0]        w_strb_q;

   // derived
   logic              wr_go;
   logic [9:0]        wr_idx;
   logic [9:0]        rd_idx;
   logic              wr_lane0;
   logic [N_PINS-1:0] pin_event;
   logic [N_PINS-1:0] pin_clear;
   logic [N_PINS-1:0] wr_mask;
   logic [NUM_SRC-1:0] flags;
   logic [NUM_SRC-1:0] enables;
   logic [NUM_SRC-1:0] priorities;
   logic [NUM_SRC-1:0] active;
   logic [7:0]        extended_flag_reg;
   logic              rtc_timer_line_flag;
   logic              spi_slave_line_flag;
   logic              pca_line_flag;
   logic              adc_pwm_line_flag;
   logic              comparator_can_line_flag;
   logic              low_voltage_line_flag;
   logic              global_irq_enable;
   core_request_s     next_core_request;
   logic [DATA_W-1:0] next_rdata;
   logic [1:0]        next_rresp;

   // handshakes are combinational; ce low refuses new traffic
   assign awready = ce & ~aw_full;
   assign wready  = ce & ~w_full;
   assign arready = ce & ~rvalid;
   assign wr_go   = ce & aw_full & w_full & ~bvalid;
   assign wr_idx  = aw_addr_q[11:2];
   assign rd_idx  = araddr[11:2];
   assign wr_lane0 = w_strb_q[0];

   // byte-lane mask for the wide pin registers
   always_comb begin
      wr_mask = '0;
      for (int i = 0; i < N_PINS; i++) begin
         wr_mask[i] = w_strb_q[i / 8];
      end
   end

   // write address and data are captured independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full   <= 1'b0;
         aw_addr_q <= '0;
      end else if (ce) begin
         if (awvalid && !aw_full) begin
            aw_full   <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (wr_go) begin
            aw_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full   <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (ce) begin
         if (wvalid && !w_full) begin
            w_full   <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end else if (wr_go) begin
            w_full <= 1'b0;
         end
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (ce) begin
         if (wr_go) begin
            bvalid <= 1'b1;
            unique case (wr_idx)
               IDX_EXT_FLAGS, IDX_BASE_EN, IDX_BASE_PRIO, IDX_EXT_EN, IDX_EXT_PRIO,
               IDX_PIN_GROUP, IDX_PIN_RISE, IDX_PIN_FALL, IDX_PIN_FLAGS, IDX_PIN_WAKE,
               IDX_CORE_STAT: bresp <= RESP_OKAY;
               default:       bresp <= RESP_SLVERR;
            endcase
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // 8-bit control registers, written through byte lane 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_enable_reg       <= RST_REG8;
         base_priority_reg     <= RST_REG8;
         extended_enable_reg   <= RST_REG8;
         extended_priority_reg <= RST_REG8;
      end else if (wr_go && wr_lane0) begin
         if (wr_idx == IDX_BASE_EN) begin
            base_enable_reg <= w_data_q[7:0];
         end
         if (wr_idx == IDX_BASE_PRIO) begin
            base_priority_reg <= {1'b0, w_data_q[6:0]};
         end
         if (wr_idx == IDX_EXT_EN) begin
            extended_enable_reg <= w_data_q[7:0];
         end
         if (wr_idx == IDX_EXT_PRIO) begin
            extended_priority_reg <= w_data_q[7:0];
         end
      end
   end

   // i2c master flag: hardware sets, software writes 0 to clear; set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         i2c_master_line_flag <= 1'b0;
      end else if (ce) begin
         if (sources.i2c_master_set) begin
            i2c_master_line_flag <= 1'b1;
         end else if (wr_go && wr_lane0 && wr_idx == IDX_EXT_FLAGS && !w_data_q[BIT_I2C_FLAG]) begin
            i2c_master_line_flag <= 1'b0;
         end
      end
   end

   // pin configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_function_config <= N_PINS'(RST_REG32);
         pin_rise_en         <= N_PINS'(RST_REG32);
         pin_fall_en         <= N_PINS'(RST_REG32);
         pin_wake_en         <= N_PINS'(RST_REG32);
      end else if (wr_go) begin
         if (wr_idx == IDX_PIN_GROUP) begin
            pin_function_config <= (pin_function_config & ~wr_mask) | (w_data_q[N_PINS-1:0] & wr_mask);
         end
         if (wr_idx == IDX_PIN_RISE) begin
            pin_rise_en <= (pin_rise_en & ~wr_mask) | (w_data_q[N_PINS-1:0] & wr_mask);
         end
         if (wr_idx == IDX_PIN_FALL) begin
            pin_fall_en <= (pin_fall_en & ~wr_mask) | (w_data_q[N_PINS-1:0] & wr_mask);
         end
         if (wr_idx == IDX_PIN_WAKE) begin
            pin_wake_en <= (pin_wake_en & ~wr_mask) | (w_data_q[N_PINS-1:0] & wr_mask);
         end
      end
   end

   // pin write-one-to-clear strobes
   assign pin_clear = (wr_go && wr_idx == IDX_PIN_FLAGS) ? (w_data_q[N_PINS-1:0] & wr_mask) : '0;

   // per-pin edge detectors; a fresh edge beats a clear in the same cycle
   genvar gp;
   generate
      for (gp = 0; gp < N_PINS; gp++) begin : g_pin
         assign pin_event[gp] = (pin_rise_en[gp] & gpio_pins[gp] & ~pin_prev[gp])
                              | (pin_fall_en[gp] & ~gpio_pins[gp] & pin_prev[gp]);

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pin_flags[gp] <= 1'b0;
            end else if (ce) begin
               if (pin_event[gp]) begin
                  pin_flags[gp] <= 1'b1;
               end else if (pin_clear[gp]) begin
                  pin_flags[gp] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // previous pin level; pins are synchronous to aclk already
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev <= '0;
      end else if (ce) begin
         pin_prev <= gpio_pins;
      end
   end

   // wake pulse reuses the interrupt edge detection, so it needs no enables of the core
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_event <= 1'b0;
      end else if (ce) begin
         wake_event <= |(pin_event & pin_wake_en);
      end
   end

   // pin groups gather flags per their configured group
   assign pin_irq_group0 = |(pin_flags & ~pin_function_config);
   assign pin_irq_group1 = |(pin_flags & pin_function_config);

   // line flags are plain ORs of live peripheral flags, so a source left set keeps the line up
   assign rtc_timer_line_flag = sources.rtc_second_event | sources.rtc_alarm_event
                              | sources.rtc_quarter_second_event | (|sources.rtc_timer_other);
   assign spi_slave_line_flag      = |sources.spi_slave_src;
   assign pca_line_flag            = |sources.pca_src;
   assign adc_pwm_line_flag        = |sources.adc_pwm_src;
   assign comparator_can_line_flag = |sources.comparator_can_src;
   assign low_voltage_line_flag    = |sources.low_voltage_src;

   // readback view; bit 4 reserved reads zero
   assign extended_flag_reg = {rtc_timer_line_flag, spi_slave_line_flag, pca_line_flag, 1'b0,
                               adc_pwm_line_flag, comparator_can_line_flag, low_voltage_line_flag,
                               i2c_master_line_flag};

   // natural order: index 0 is pin group 0, index 14 the rtc/timer line
   assign flags = {rtc_timer_line_flag, spi_slave_line_flag, pca_line_flag, sources.watchdog_flag,
                   adc_pwm_line_flag, comparator_can_line_flag, low_voltage_line_flag,
                   i2c_master_line_flag, sources.uart2_flag, sources.timer2_flag, sources.uart0_flag,
                   sources.timer1_flag, pin_irq_group1, sources.timer0_flag, pin_irq_group0};
   assign enables    = {extended_enable_reg, base_enable_reg[6:0]};
   assign priorities = {extended_priority_reg, base_priority_reg[6:0]};
   assign global_irq_enable = base_enable_reg[BIT_GLOBAL_EN];
   assign active = flags & enables & {NUM_SRC{global_irq_enable}};

   // arbitration: any high level wins, ties go to the lowest index
   always_comb begin
      next_core_request = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (active[i] && !priorities[i] && !next_core_request.high) begin
            next_core_request.valid = 1'b1;
            next_core_request.index = 4'(i);
         end
      end
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (active[i] && priorities[i]) begin
            next_core_request.valid = 1'b1;
            next_core_request.high  = 1'b1;
            next_core_request.index = 4'(i);
         end
      end
   end

   // requests re-evaluated every edge, so a flag still set reasserts after return
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_request  <= '0;
         line_requests <= '0;
      end else if (ce) begin
         core_request  <= next_core_request;
         line_requests <= active;
      end
   end

   // read decode; writes to the peripheral line flags were dropped above
   always_comb begin
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      unique case (rd_idx)
         IDX_EXT_FLAGS: next_rdata[7:0] = extended_flag_reg;
         IDX_BASE_EN:   next_rdata[7:0] = base_enable_reg;
         IDX_BASE_PRIO: next_rdata[7:0] = base_priority_reg;
         IDX_EXT_EN:    next_rdata[7:0] = extended_enable_reg;
         IDX_EXT_PRIO:  next_rdata[7:0] = extended_priority_reg;
         IDX_PIN_GROUP: next_rdata[N_PINS-1:0] = pin_function_config;
         IDX_PIN_RISE:  next_rdata[N_PINS-1:0] = pin_rise_en;
         IDX_PIN_FALL:  next_rdata[N_PINS-1:0] = pin_fall_en;
         IDX_PIN_FLAGS: next_rdata[N_PINS-1:0] = pin_flags;
         IDX_PIN_WAKE:  next_rdata[N_PINS-1:0] = pin_wake_en;
         IDX_CORE_STAT: next_rdata[NUM_SRC+5:0] = {line_requests, core_request};
         default:       next_rresp = RESP_SLVERR;
      endcase
   end

   // read data registered; answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end else if (ce) begin
         if (arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule

// ---- verif/irq_checker.sv ----
module irq_checker
   import irq_pkg::*;
#(
   parameter int unsigned N_PINS = 32
) (
   input wire logic                         aclk,
   input wire logic                         aresetn,
   input wire logic                         awvalid,
   input wire logic                         awready,
   input wire logic                         wvalid,
   input wire logic                         wready,
   input wire logic                         bvalid,
   input wire logic                         arvalid,
   input wire logic                         arready,
   input wire logic                         rvalid,
   input wire logic [N_PINS-1:0]            gpio_pins,
   input wire irq_pkg::core_request_s       core_request,
   input wire logic [irq_pkg::NUM_SRC-1:0]  line_requests,
   input wire logic                         pin_irq_group0,
   input wire logic                         pin_irq_group1,
   input wire logic                         wake_event
);
   timeunit 1ns;
   timeprecision 1ps;
   import irq_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // both write halves taken on one edge, then the write lands one edge later
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd_taken;
      arvalid && arready;
   endsequence
   // a pin flag can only appear after the sampled pin level changed
   sequence s_pin_moved;
      $past(gpio_pins) != $past(gpio_pins, 2);
   endsequence

   property p_valid_iff_line;
      core_request.valid == (|line_requests);
   endproperty
   property p_winner_asks;
      core_request.valid |-> core_request.index < 4'd15 && line_requests[core_request.index];
   endproperty
   property p_low_lowest;
      core_request.valid && !core_request.high |-> (line_requests & ((15'h1 << core_request.index) - 15'h1)) == 15'h0;
   endproperty
   property p_wr_answer;
      s_wr_taken |-> ##2 bvalid;
   endproperty
   property p_rd_answer;
      s_rd_taken |=> rvalid;
   endproperty
   property p_rd_block;
      rvalid |-> !arready;
   endproperty
   property p_pin_cause;
      $rose(pin_irq_group0) || $rose(pin_irq_group1) |-> s_pin_moved;
   endproperty
   property p_wake_cause;
      $rose(wake_event) |-> s_pin_moved;
   endproperty

   a_valid_iff_line: assert property (p_valid_iff_line) else $error("core valid differs from line requests");
   a_winner_asks: assert property (p_winner_asks) else $error("winner is not a requesting line");
   a_low_lowest: assert property (p_low_lowest) else $error("low winner is not the lowest index");
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   a_rd_block: assert property (p_rd_block) else $error("read address taken while answer pending");
   a_pin_cause: assert property (p_pin_cause) else $error("pin group raised without pin edge");
   a_wake_cause: assert property (p_wake_cause) else $error("wake without pin edge");
endmodule

bind extended_irq_ctrl irq_checker #(.N_PINS(N_PINS)) checker_i (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .gpio_pins(gpio_pins),
   .core_request(core_request), .line_requests(line_requests), .pin_irq_group0(pin_irq_group0),
   .pin_irq_group1(pin_irq_group1), .wake_event(wake_event)
);

// ---- verif/periph_model.sv ----
module periph_model
   import irq_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire irq_pkg::irq_sources_s raise,
   input  wire irq_pkg::irq_sources_s clear,
   output irq_pkg::irq_sources_s      sources
);
   timeunit 1ns;
   timeprecision 1ps;
   import irq_pkg::*;

   // each peripheral except the i2c master set pulse holds its flag until its own clear; the block never clears them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sources <= '0;
      end else begin
         sources <= (sources | raise) & ~clear;
         sources.i2c_master_set <= raise.i2c_master_set; // a set pulse only, no storage here
      end
   end
endmodule

// ---- verif/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_pkg::*;

   typedef struct {logic wr; logic [9:0] idx; logic [31:0] d; logic [31:0] exp; logic [1:0] resp;} row_s;
   localparam logic [9:0] IDX_NONE = 10'h0ff; // no register lives here

   logic          aclk = 1'b0, aresetn = 1'b0;
   logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0]   awaddr = 12'h000, araddr = 12'h000;
   logic [31:0]   wdata = 32'h0, gpio_pins = 32'h0, data;
   logic [1:0]    resp, bresp, rresp;
   logic [31:0]   rdata;
   logic          awready, wready, bvalid, arready, rvalid, pin_irq_group0, pin_irq_group1, wake_event;
   logic [14:0]   line_requests;
   core_request_s core_request;
   irq_sources_s  raise = '0, clear = '0, sources, z = '0;
   int            fail_count = 0, n_compared = 0, wake_cnt = 0;
   row_s          rows [15] = '{
      '{1'b0, IDX_EXT_FLAGS, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, IDX_BASE_EN, 32'h0, 32'h0, RESP_OKAY},
      '{1'b0, IDX_BASE_PRIO, 32'h0, 32'h0, RESP_OKAY}, '{1'b0, IDX_EXT_EN, 32'h0, 32'h0, RESP_OKAY},
      '{1'b0, IDX_EXT_PRIO, 32'h0, 32'h0, RESP_OKAY}, '{1'b1, IDX_BASE_PRIO, 32'h0000_00ff, 32'h0, RESP_OKAY},
      '{1'b0, IDX_BASE_PRIO, 32'h0, 32'h0000_007f, RESP_OKAY}, '{1'b1, IDX_EXT_EN, 32'h0000_00a5, 32'h0, RESP_OKAY},
      '{1'b0, IDX_EXT_EN, 32'h0, 32'h0000_00a5, RESP_OKAY}, '{1'b1, IDX_EXT_PRIO, 32'h0000_005a, 32'h0, RESP_OKAY},
      '{1'b0, IDX_EXT_PRIO, 32'h0, 32'h0000_005a, RESP_OKAY}, '{1'b1, IDX_EXT_FLAGS, 32'h0000_00fe, 32'h0, RESP_OKAY},
      '{1'b0, IDX_EXT_FLAGS, 32'h0, 32'h0, RESP_OKAY}, '{1'b1, IDX_NONE, 32'h1, 32'h0, RESP_SLVERR},
      '{1'b0, IDX_NONE, 32'h0, 32'h0, RESP_SLVERR}};

   extended_irq_ctrl dut (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sources(sources), .gpio_pins(gpio_pins),
      .core_request(core_request), .line_requests(line_requests), .pin_irq_group0(pin_irq_group0),
      .pin_irq_group1(pin_irq_group1), .wake_event(wake_event));
   periph_model far_i (.aclk(aclk), .aresetn(aresetn), .raise(raise), .clear(clear), .sources(sources));

   always #4 aclk = ~aclk;
   // wake pulses counted mid-cycle, away from the edge that launches them
   always @(negedge aclk) if (wake_event === 1'b1) wake_cnt++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // handshakes are judged mid-cycle, acted on just after the edge
   task automatic wr(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] r);
      logic a, w, b;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge aclk);
         a = awvalid && awready;
         w = wvalid && wready;
         b = bvalid && bready;
         r = bresp;
         @(posedge aclk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic a, b;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge aclk);
         a = arvalid && arready;
         b = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (a) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   task automatic rchk(input logic [9:0] idx, input logic [31:0] exp, input string nm);
      rd(idx, data, resp);
      chk(data, exp, nm);
   endtask

   // one event from the far side: raise or clear for a single cycle, then let lines settle
   task automatic ev(input irq_sources_s r, input irq_sources_s c);
      @(posedge aclk);
      raise <= r;
      clear <= c;
      @(posedge aclk);
      raise <= '0;
      clear <= '0;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic pin(input logic [31:0] v);
      @(posedge aclk);
      gpio_pins <= v;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // watchdog sized well past the few hundred cycles the sequence needs
   initial begin
      repeat (5000) @(posedge aclk);
      fail_count++;
      close_out();
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].idx, rows[i].d, resp);
         else rd(rows[i].idx, data, resp);
         if (!rows[i].wr) chk(data, rows[i].exp, "table data");
         chk({30'h0, resp}, {30'h0, rows[i].resp}, "table resp");
      end
      wr(IDX_EXT_EN, 32'h0, resp);
      wr(IDX_EXT_PRIO, 32'h0, resp);
      wr(IDX_BASE_PRIO, 32'h0, resp); // the table left base priorities high
      $display("register table done");
      ev('{rtc_second_event: 1'b1, rtc_alarm_event: 1'b1, default: '0}, z);
      rchk(IDX_EXT_FLAGS, 32'h0000_0080, "rtc line set");
      wr(IDX_EXT_FLAGS, 32'h0, resp);
      rchk(IDX_EXT_FLAGS, 32'h0000_0080, "line flag write");
      ev(z, '{rtc_second_event: 1'b1, default: '0});
      rchk(IDX_EXT_FLAGS, 32'h0000_0080, "shared line held");
      ev(z, '{rtc_alarm_event: 1'b1, default: '0});
      rchk(IDX_EXT_FLAGS, 32'h0, "line follows");
      ev('{rtc_quarter_second_event: 1'b1, default: '0}, z);
      rchk(IDX_EXT_FLAGS, 32'h0000_0080, "quarter event");
      ev(z, '{rtc_quarter_second_event: 1'b1, default: '0});
      $display("shared line done");
      wr(IDX_EXT_FLAGS, 32'h1, resp);
      rchk(IDX_EXT_FLAGS, 32'h0, "write cannot set");
      ev('{i2c_master_set: 1'b1, default: '0}, z);
      wr(IDX_EXT_FLAGS, 32'h1, resp);
      rchk(IDX_EXT_FLAGS, 32'h1, "i2c flag kept");
      wr(IDX_EXT_FLAGS, 32'h0, resp);
      rchk(IDX_EXT_FLAGS, 32'h0, "i2c flag cleared");
      $display("i2c flag done");
      ev('{timer0_flag: 1'b1, rtc_second_event: 1'b1, default: '0}, z);
      wr(IDX_EXT_EN, 32'h0000_0080, resp);
      wr(IDX_BASE_EN, 32'h0000_0002, resp);
      ev(z, z);
      chk({17'h0, line_requests}, 32'h0, "no global enable");
      wr(IDX_BASE_EN, 32'h0000_0082, resp);
      ev(z, z);
      chk({17'h0, line_requests}, 32'h0000_4002, "lines asking");
      chk({26'h0, core_request}, 32'h0000_0021, "low order winner");
      wr(IDX_EXT_PRIO, 32'h0000_0080, resp);
      ev(z, z);
      chk({26'h0, core_request}, 32'h0000_003e, "high level winner");
      wr(IDX_EXT_EN, 32'h0000_0081, resp);
      ev('{i2c_master_set: 1'b1, default: '0}, z);
      chk({17'h0, line_requests}, 32'h0000_4082, "i2c line");
      $display("arbitration done");
      wr(IDX_PIN_GROUP, 32'h1, resp);
      wr(IDX_PIN_RISE, 32'h3, resp);
      wr(IDX_PIN_FALL, 32'h2, resp);
      wr(IDX_PIN_WAKE, 32'h1, resp);
      pin(32'h0000_0001);
      chk({30'h0, pin_irq_group1, pin_irq_group0}, 32'h2, "pin0 rise");
      chk(wake_cnt, 32'h1, "wake count");
      wr(IDX_PIN_FLAGS, 32'h3, resp);
      pin(32'h0);
      chk({30'h0, pin_irq_group1, pin_irq_group0}, 32'h0, "pin0 fall ignored");
      pin(32'h0000_0002);
      chk({30'h0, pin_irq_group1, pin_irq_group0}, 32'h1, "pin1 rise");
      wr(IDX_PIN_FLAGS, 32'h3, resp);
      pin(32'h0);
      chk({30'h0, pin_irq_group1, pin_irq_group0}, 32'h1, "pin1 fall");
      chk(wake_cnt, 32'h1, "wake only enabled pin");
      $display("pin groups done");
      // mid-run reset while the i2c flag and a pin flag are still set
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(IDX_EXT_FLAGS, 32'h0, "reset ext flags");
      rchk(IDX_PIN_FLAGS, 32'h0, "reset pin flags");
      $display("mid-run reset done");
      close_out();
   end
endmodule
